// ---- shared/psc_defines.svh ----
// register offsets, field positions, write masks, response codes and timing counts of the power-save block
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_OFF_CTRL 12'h000
`define PSC_OFF_CLOCK_DIVIDER_REG 12'h004
`define PSC_OFF_MODDIS 12'h008
`define PSC_OFF_STATUS 12'h00c
`define PSC_CPU_SLOWDOWN_ENABLE_BIT 11
`define PSC_ROI_BIT 15
`define PSC_RATIO_LO 12
`define PSC_RATIO_HI 14
`define PSC_CTRL_WDT_EN 0
`define PSC_CTRL_CLOCK_FAIL_MONITOR_EN 1
`define PSC_CLOCK_DIVIDER_REG_MASK 16'hf800
`define PSC_MODDIS_MASK 16'hfaa9
`define PSC_ADC_BIT 0
`define PSC_WAKE_DLY 3'h3
`define PSC_RESP_OKAY 2'h0
`define PSC_RESP_SLVERR 2'h2
`endif

// ---- shared/psc_pkg.sv ----
// types shared by the power-save clock control block
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_RUN = 2'b00,
    PSC_SLEEP = 2'b01,
    PSC_IDLE = 2'b10,
    PSC_WAKE = 2'b11
  } psc_mode_t;
  typedef struct packed {
    logic valid;
    logic sleep_sel;
  } psc_power_save_instruction_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic low_power_rc_osc_en;
    logic clock_fail_monitor_active;
    logic wdt_clear;
    logic periph_sysclk_en;
  } psc_clk_ctl_t;
  typedef struct packed {
    psc_mode_t mode;
    logic [2:0] wake_cnt;
    logic pend_q;
    logic wdt_en;
    logic clock_fail_monitor_en;
    logic return_on_interrupt;
    logic cpu_slowdown_enable;
    logic [2:0] ratio;
    logic [6:0] doze_cnt;
    logic [15:0] moddis;
    logic [15:0] moddis_eff;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic have_aw;
    logic have_w;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } psc_state_t;
endpackage

// ---- core/psc_power_ctrl.sv ----
// power-save mode control, cpu slowdown divider and module clock disables
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "psc_defines.svh"
// Notes on behaviour
// R1 - sleep or idle entered only by instruction
// R2 - idle stops cpu, peripherals keep running
// R3 - sleep stops system clock and oscillator
// R4 - clock fail monitor off during sleep
// R5 - rc oscillator runs in sleep if watchdog
// R6 - watchdog count cleared before sleep
// R7 - system clocked peripherals off in sleep
// R8 - sleep exits on interrupt, reset, timeout
// R9 - sleep wake resumes same clock source
// R10 - watchdog count cleared entering idle
// R11 - idle keeps system clock and rc oscillator
// R12 - idle exits on interrupt, reset, timeout
// R13 - idle wake resumes cpu 2-4 cycles later
// R14 - coincident interrupt deferred then wakes device
// R15 - doze slows cpu clock synchronously only
// R16 - doze active when enable bit 11 set
// R17 - ratio bits 14:12 select 1:1..1:128
// R18 - return on interrupt ends doze
// R19 - disable bit stops module clocks, registers
// R20 - present modules enabled after reset
// R21 - disable change takes effect one cycle later
// R22 - register one bit map, adc pins digital
// R23 - ratio code is power of two divider
module psc_power_ctrl
  import psc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu side
  input wire psc_pkg::psc_power_save_instruction_t power_save_instruction,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  // clock controls toward oscillators, watchdog and peripherals
  output psc_pkg::psc_clk_ctl_t clk_ctl,
  output psc_pkg::psc_mode_t mode,
  output logic [15:0] module_clk_en,
  output logic adc_pins_digital
);
  import psc_pkg::*;

  psc_state_t s_q, s_d;
  logic wake_ev;
  logic doze_tick;
  logic wr_fire;
  logic [15:0] wd16;

  // byte-lane merge of the low half of a register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st, input logic [15:0] msk);
    logic [15:0] r;
    r = old;
    if (st[0])
    begin
      r[7:0] = d[7:0];
    end
    if (st[1])
    begin
      r[15:8] = d[15:8];
    end
    return r & msk;
  endfunction

  // -----------------------------------------------------------------
  // wake and doze decode
  // -----------------------------------------------------------------
  assign wake_ev = irq_pending | wdt_timeout; // R8 R12
  // divider terminal count: ratio code n gives 2**n, so mask the low n bits
  assign doze_tick = ((s_q.doze_cnt & ((7'h01 << s_q.ratio) - 7'h01)) == 7'h00); // R23 R17
  assign wr_fire = s_q.have_aw && s_q.have_w && !s_q.bvalid;
  assign wd16 = s_q.wdata[15:0];

  always_comb
  begin
    s_d = s_q;
    // -----------------------------------------------------------------
    // mode machine
    // -----------------------------------------------------------------
    case (s_q.mode)
      PSC_RUN:
      begin
        if (power_save_instruction.valid) // R1
        begin
          s_d.mode = power_save_instruction.sleep_sel ? PSC_SLEEP : PSC_IDLE;
          // an interrupt during the instruction is held until entry completes
          s_d.pend_q = wake_ev; // R14
        end
      end
      PSC_SLEEP, PSC_IDLE:
      begin
        s_d.pend_q = 1'b0;
        if (wake_ev || s_q.pend_q) // R8 R12 R14
        begin
          s_d.mode = PSC_WAKE;
          s_d.wake_cnt = `PSC_WAKE_DLY;
        end
      end
      PSC_WAKE:
      begin
        s_d.wake_cnt = s_q.wake_cnt - 3'h1;
        if (s_q.wake_cnt == 3'h1) // R13
        begin
          s_d.mode = PSC_RUN;
        end
      end
      default:
      begin
        s_d.mode = PSC_RUN;
      end
    endcase
    // -----------------------------------------------------------------
    // doze divider, kept aligned to the peripheral clock
    // -----------------------------------------------------------------
    s_d.doze_cnt = s_q.doze_cnt + 7'h01; // R15
    if (s_q.cpu_slowdown_enable && s_q.return_on_interrupt && irq_pending)
    begin
      s_d.cpu_slowdown_enable = 1'b0; // R18
    end
    // module disables reach the modules one cycle after the write lands
    s_d.moddis_eff = s_q.moddis; // R21
    // -----------------------------------------------------------------
    // axi4-lite write channel
    // -----------------------------------------------------------------
    s_d.awready = 1'b0;
    s_d.wready = 1'b0;
    if (s_axi_awvalid && !s_q.have_aw && !s_q.awready)
    begin
      s_d.awready = 1'b1;
      s_d.have_aw = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.have_w && !s_q.wready)
    begin
      s_d.wready = 1'b1;
      s_d.have_w = 1'b1;
      s_d.wdata = s_axi_wdata;
    end
    if (wr_fire)
    begin
      s_d.have_aw = 1'b0;
      s_d.have_w = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `PSC_RESP_OKAY;
      if (s_q.awaddr == `PSC_OFF_CTRL)
      begin
        if (s_axi_wstrb[0])
        begin
          s_d.wdt_en = wd16[`PSC_CTRL_WDT_EN];
          s_d.clock_fail_monitor_en = wd16[`PSC_CTRL_CLOCK_FAIL_MONITOR_EN];
        end
      end
      else if (s_q.awaddr == `PSC_OFF_CLOCK_DIVIDER_REG)
      begin
        if (s_axi_wstrb[1])
        begin
          s_d.cpu_slowdown_enable = wd16[`PSC_CPU_SLOWDOWN_ENABLE_BIT]; // R16
          s_d.return_on_interrupt = wd16[`PSC_ROI_BIT]; // R18
          s_d.ratio = wd16[`PSC_RATIO_HI:`PSC_RATIO_LO]; // R17
        end
      end
      else if (s_q.awaddr == `PSC_OFF_MODDIS)
      begin
        s_d.moddis = merge16(s_q.moddis, s_q.wdata, s_axi_wstrb, `PSC_MODDIS_MASK); // R22
      end
      else if (s_q.awaddr != `PSC_OFF_STATUS)
      begin
        s_d.bresp = `PSC_RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    // -----------------------------------------------------------------
    // axi4-lite read channel
    // -----------------------------------------------------------------
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `PSC_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (s_axi_araddr == `PSC_OFF_CTRL)
      begin
        s_d.rdata[`PSC_CTRL_WDT_EN] = s_q.wdt_en;
        s_d.rdata[`PSC_CTRL_CLOCK_FAIL_MONITOR_EN] = s_q.clock_fail_monitor_en;
      end
      else if (s_axi_araddr == `PSC_OFF_CLOCK_DIVIDER_REG)
      begin
        s_d.rdata[`PSC_CPU_SLOWDOWN_ENABLE_BIT] = s_q.cpu_slowdown_enable;
        s_d.rdata[`PSC_ROI_BIT] = s_q.return_on_interrupt;
        s_d.rdata[`PSC_RATIO_HI:`PSC_RATIO_LO] = s_q.ratio;
      end
      else if (s_axi_araddr == `PSC_OFF_MODDIS)
      begin
        s_d.rdata[15:0] = s_q.moddis;
      end
      else if (s_axi_araddr == `PSC_OFF_STATUS)
      begin
        s_d.rdata[1:0] = s_q.mode;
      end
      else
      begin
        s_d.rresp = `PSC_RESP_SLVERR;
      end
    end
    else if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0; // R20
      s_q.mode <= PSC_RUN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  always_comb
  begin
    clk_ctl.sys_clk_en = (s_q.mode != PSC_SLEEP); // R3 R11 R9
    clk_ctl.cpu_clk_en = (s_q.mode == PSC_RUN) && (!s_q.cpu_slowdown_enable || doze_tick); // R2 R15
    clk_ctl.clock_fail_monitor_active = s_q.clock_fail_monitor_en && (s_q.mode != PSC_SLEEP); // R4
    clk_ctl.low_power_rc_osc_en = (s_q.mode == PSC_SLEEP) ? s_q.wdt_en
                      : (s_q.wdt_en || s_q.clock_fail_monitor_en); // R5 R11
    // pulse at the instruction, one cycle before the new mode shows
    clk_ctl.wdt_clear = s_q.wdt_en && power_save_instruction.valid && (s_q.mode == PSC_RUN); // R6 R10
    clk_ctl.periph_sysclk_en = (s_q.mode != PSC_SLEEP); // R7 R2
  end

  assign mode = s_q.mode;
  // ungated clock is also cut in sleep; external-clock peripherals are not gated here
  assign module_clk_en = ~s_q.moddis_eff & {16{s_q.mode != PSC_SLEEP}}; // R19 R21
  assign adc_pins_digital = s_q.moddis_eff[`PSC_ADC_BIT]; // R22
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_axi_arvalid && !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_entry_by_instr: assert property ((s_q.mode == PSC_RUN) && !power_save_instruction.valid
    |=> s_q.mode == PSC_RUN) else $error("low power entered without instruction"); // R1
  a_idle_cpu_stop: assert property ((s_q.mode == PSC_IDLE) |-> !clk_ctl.cpu_clk_en
    && clk_ctl.sys_clk_en) else $error("idle clock gating wrong"); // R2
  a_sleep_sysclk: assert property ((s_q.mode == PSC_SLEEP) |-> !clk_ctl.sys_clk_en
    && !clk_ctl.cpu_clk_en) else $error("sleep left system clock on"); // R3
  a_sleep_no_clock_fail_monitor: assert property ((s_q.mode == PSC_SLEEP) |-> !clk_ctl.clock_fail_monitor_active)
    else $error("fail monitor active in sleep"); // R4
  a_sleep_low_power_rc_osc: assert property ((s_q.mode == PSC_SLEEP) && s_q.wdt_en |-> clk_ctl.low_power_rc_osc_en)
    else $error("rc oscillator off in sleep"); // R5
  a_wdt_clear: assert property ((s_q.mode == PSC_RUN) && power_save_instruction.valid && s_q.wdt_en
    |-> clk_ctl.wdt_clear) else $error("watchdog not cleared on entry"); // R6
  a_periph_off: assert property ((s_q.mode == PSC_SLEEP) |-> module_clk_en == 16'h0000)
    else $error("peripheral clock in sleep"); // R7
  a_wake_exit: assert property ((s_q.mode == PSC_SLEEP || s_q.mode == PSC_IDLE) && wake_ev
    |=> s_q.mode == PSC_WAKE) else $error("no wake on event"); // R8
  a_wake_delay: assert property ($rose(s_q.mode == PSC_WAKE) |-> ##[2:4] clk_ctl.cpu_clk_en
    || s_q.cpu_slowdown_enable) else $error("wake delay out of range"); // R13
  a_coincident: assert property ((s_q.mode == PSC_RUN) && power_save_instruction.valid && wake_ev
    |=> (s_q.mode != PSC_RUN) ##1 s_q.mode == PSC_WAKE)
    else $error("coincident interrupt lost"); // R14
  a_doze_rate: assert property ((s_q.mode == PSC_RUN) && !s_q.cpu_slowdown_enable |-> clk_ctl.cpu_clk_en)
    else $error("cpu slowed without doze"); // R16
  a_roi_exit: assert property (s_q.cpu_slowdown_enable && s_q.return_on_interrupt && irq_pending && !wr_fire
    |=> !s_q.cpu_slowdown_enable) else $error("return on interrupt ignored"); // R18
  // entering sleep cuts every module clock, so the lag is only checked outside it
  a_moddis_lag: assert property ((s_q.mode != PSC_SLEEP) |-> ##1
    (s_q.mode == PSC_SLEEP) || module_clk_en == ~$past(s_q.moddis))
    else $error("disable timing wrong"); // R21

  c_sleep_wake: cover property (s_q.mode == PSC_SLEEP ##1 s_q.mode == PSC_WAKE);
  c_idle_wake: cover property (s_q.mode == PSC_IDLE ##1 s_q.mode == PSC_WAKE);
  c_doze_run: cover property (s_q.cpu_slowdown_enable && s_q.ratio == 3'h2 && clk_ctl.cpu_clk_en);
  c_moddis_wr: cover property (wr_fire && s_q.awaddr == `PSC_OFF_MODDIS);
endmodule // psc_power_ctrl

// ---- tb/psc_cpu_model.sv ----
// processor core model: issues power-save instructions and raises wake sources
`timescale 1ns/10ps
module psc_cpu_model
  import psc_pkg::*;
(
  // clock
  input wire logic aclk,
  // toward the block
  output psc_pkg::psc_power_save_instruction_t power_save_instruction,
  output logic irq_pending,
  output logic wdt_timeout,
  // from the block
  input wire psc_pkg::psc_clk_ctl_t clk_ctl
);
  // ----------------------------------------
  // instruction and wake sequencing
  // ----------------------------------------
  initial
  begin
    power_save_instruction = '0;
    irq_pending = 1'b0;
    wdt_timeout = 1'b0;
  end
  // one-cycle instruction, optionally raising an interrupt in the same cycle that is left up afterwards
  task automatic instr(input logic sel, input logic co);
    @(posedge aclk);
    power_save_instruction <= '{1'b1, sel};
    irq_pending <= co;
    @(posedge aclk);
    power_save_instruction <= '0;
  endtask
  // the source is held until the core runs again, as a handler would clear it
  task automatic wake(input logic use_wdt, output int n);
    repeat ($urandom_range(3, 0)) @(posedge aclk);
    @(posedge aclk);
    if (use_wdt)
      wdt_timeout <= 1'b1;
    else
      irq_pending <= 1'b1;
    // sampled mid-cycle, where the gated enable has settled
    for (n = 0; n == 0 || !clk_ctl.cpu_clk_en; n++) @(negedge aclk);
    @(posedge aclk);
    wdt_timeout <= 1'b0;
    irq_pending <= 1'b0;
  endtask
  task automatic irq_pulse;
    @(posedge aclk);
    irq_pending <= 1'b1;
    repeat (2) @(posedge aclk);
    irq_pending <= 1'b0;
  endtask
endmodule // psc_cpu_model

// ---- tb/tb.sv ----
// self-checking bench for the power-save clock control block
`timescale 1ns/10ps
`include "psc_defines.svh"
module tb;
  import psc_pkg::*;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  psc_power_save_instruction_t power_save_instruction;
  psc_clk_ctl_t clk_ctl;
  psc_mode_t mode;
  logic irq_pending, wdt_timeout, adc_pins_digital, clr_seen;
  logic [15:0] module_clk_en, v;
  logic [33:0] exp_q[$];
  int n_fail, samples_checked, cyc, n, k, r;

  psc_power_ctrl uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .power_save_instruction, .irq_pending, .wdt_timeout, .clk_ctl, .mode, .module_clk_en,
    .adc_pins_digital
  );
  psc_cpu_model cpu (.aclk, .power_save_instruction, .irq_pending, .wdt_timeout, .clk_ctl);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw, pb, ta, tw, tr;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // handshakes are judged mid-cycle, on values that stand at the next rising edge
    while (pa || pw || pb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (ta) pa = 1'b0;
      if (tw) pw = 1'b0;
      if (tr) pb = 1'b0;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
      s_axi_bready <= pb;
    end
  endtask
  // the expected answer is queued here and compared by the read watcher
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
    logic t;
    @(posedge aclk);
    exp_q.push_back({rs, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end
    while (!t);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      t = s_axi_rvalid;
      @(posedge aclk);
    end
    while (!t);
    s_axi_rready <= 1'b0;
  endtask

  // looked at mid-cycle: the answer stands there until the edge that takes it
  always @(negedge aclk)
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata} === exp_q.pop_front(), "read data");
  always @(negedge aclk)
    if (power_save_instruction.valid)
      clr_seen <= clk_ctl.wdt_clear;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      n_fail++;
      complete_run;
    end
  end
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'hbc58c664));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(module_clk_en === 16'hffff && mode === PSC_RUN, "reset state");
    rd(`PSC_OFF_CTRL, 32'h0, `PSC_RESP_OKAY);
    rd(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h0, `PSC_RESP_OKAY);
    rd(`PSC_OFF_MODDIS, 32'h0, `PSC_RESP_OKAY);
    rd(12'h010, 32'h0, `PSC_RESP_SLVERR);
    $display("test registers done");
    repeat (4)
    begin
      v = 16'($urandom);
      wr(`PSC_OFF_MODDIS, {16'h0, v});
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk(module_clk_en === ~(v & `PSC_MODDIS_MASK), "module clocks");
      chk(adc_pins_digital === v[0], "adc pins");
      rd(`PSC_OFF_MODDIS, {16'h0, v & `PSC_MODDIS_MASK}, `PSC_RESP_OKAY);
    end
    wr(`PSC_OFF_MODDIS, 32'h0);
    $display("test module disable done");
    wr(`PSC_OFF_CTRL, 32'h3);
    cpu.instr(1'b1, 1'b0);
    @(negedge aclk);
    chk(clr_seen === 1'b1, "clear before sleep");
    chk(mode === PSC_SLEEP && clk_ctl.sys_clk_en === 1'b0, "sleep clock");
    chk(clk_ctl.clock_fail_monitor_active === 1'b0 && clk_ctl.low_power_rc_osc_en === 1'b1, "sleep osc");
    chk(clk_ctl.periph_sysclk_en === 1'b0 && module_clk_en === 16'h0, "sleep periph");
    cpu.instr(1'b0, 1'b0);
    @(negedge aclk);
    chk(mode === PSC_SLEEP && clr_seen === 1'b0, "instr ignored");
    cpu.wake(1'b0, n);
    chk(n >= 3 && n <= 5 && clk_ctl.sys_clk_en === 1'b1, "sleep wake");
    cpu.instr(1'b0, 1'b0);
    @(negedge aclk);
    chk(clr_seen === 1'b1 && mode === PSC_IDLE, "idle entry");
    chk(clk_ctl.cpu_clk_en === 1'b0 && module_clk_en === 16'hffff, "idle cpu");
    chk(clk_ctl.sys_clk_en === 1'b1 && clk_ctl.low_power_rc_osc_en === 1'b1, "idle clocks");
    cpu.wake(1'b1, n);
    chk(n >= 3 && n <= 5 && mode === PSC_RUN, "idle wake");
    cpu.instr(1'b0, 1'b1);
    @(negedge aclk);
    chk(mode === PSC_IDLE, "deferred entry");
    cpu.wake(1'b0, n);
    chk(n <= 5 && mode === PSC_RUN, "deferred wake");
    $display("test sleep idle done");
    for (r = 0; r < 8; r++)
    begin
      wr(`PSC_OFF_CLOCK_DIVIDER_REG, (32'(r) << 12) | 32'h800);
      n = 0;
      k = 0;
      repeat (256)
      begin
        @(negedge aclk);
        n += int'(clk_ctl.cpu_clk_en);
        k += int'(clk_ctl.sys_clk_en & clk_ctl.periph_sysclk_en);
      end
      chk(n == (256 >> r) && k == 256, "doze ratio");
    end
    rd(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h7800, `PSC_RESP_OKAY);
    wr(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h3800);
    cpu.irq_pulse();
    rd(`PSC_OFF_CLOCK_DIVIDER_REG, 32'h3800, `PSC_RESP_OKAY);
    wr(`PSC_OFF_CLOCK_DIVIDER_REG, 32'hb800);
    cpu.irq_pulse();
    rd(`PSC_OFF_CLOCK_DIVIDER_REG, 32'hb000, `PSC_RESP_OKAY);
    $display("test doze done");
    @(posedge aclk);
    chk(exp_q.size() == 0, "reads answered");
    complete_run;
  end
endmodule // tb
